/* hw/ursts_core.sv */
// Serial receiver with status flags, receive queue and interrupt logic
//
// Function
// - Address-only capture in nine-bit mode when enabled
// - Idle flag reads one when receiver idle
// - Parity flag describes head-of-queue character
// - Framing flag describes head-of-queue character
// - Overrun set by hardware, never by software
// - Clearing overrun empties queue and shift register
// - Data-available flag high while queue nonempty
`timescale 1ns/1ps
module ursts_core
    import ursts_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              resetn_i,
    input  wire logic              ce_i,
    input  wire logic              rx_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    output logic                   irq_o
);

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] t);
        hit = (a == t);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic              rx_meta_q;
    logic              rx_sync_q;
    ursts_rx_state_e   state_q;
    ursts_rx_state_e   state_d;
    logic [15:0]       cnt_q;
    logic [15:0]       cnt_d;
    logic [3:0]        bit_q;
    logic [3:0]        bit_d;
    logic [CHAR_W-1:0] shift_q;
    logic [CHAR_W-1:0] shift_d;
    logic              par_q;
    logic              par_d;
    logic              done_w;
    logic              address_detect_enable_q;
    logic [MODE_W-1:0] mode_q;
    logic [15:0]       baud_q;
    logic              overrun_q;
    logic [CNT_W-1:0]  count_q;
    logic [CNT_W-1:0]  count_d;
    logic [PTR_W-1:0]  wptr_q;
    logic [PTR_W-1:0]  wptr_d;
    logic [PTR_W-1:0]  rptr_q;
    logic [PTR_W-1:0]  rptr_d;
    logic [INT_W-1:0]  int_stat_q;
    logic [INT_W-1:0]  int_stat_d;
    logic [INT_W-1:0]  int_mask_q;
    logic [INT_W-1:0]  int_ev_w;
    logic [DATA_W-1:0] status_w;
    logic [DATA_W-1:0] rd_mux_w;
    ursts_entry_s      head_w;
    ursts_entry_s      entry_w;

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    wire              nine_w     = mode_q[MODE_NINE];
    wire [PAR_W-1:0]  par_mode_w = mode_q[MODE_PAR +: PAR_W];
    wire              par_en_w   = (par_mode_w != PAR_NONE) && !nine_w;
    wire              tick_w     = (cnt_q == 16'h0000);
    // Kept out of the state process so the overrun logic forms no loop through it
    assign done_w = (state_q == ST_STOP) && tick_w;
    wire [3:0]        last_w     = nine_w ? LAST_9 : LAST_8;
    wire              wr_stat_w  = wr_i && hit(addr_i, ADDR_STATUS);
    wire              wr_mode_w  = wr_i && hit(addr_i, ADDR_MODE);
    wire              wr_baud_w  = wr_i && hit(addr_i, ADDR_BAUD);
    wire              wr_ist_w   = wr_i && hit(addr_i, ADDR_INT_STAT);
    wire              wr_imask_w = wr_i && hit(addr_i, ADDR_INT_MASK);
    wire              avail_w    = (count_q != '0);
    wire              full_w     = (count_q == CNT_FULL);
    wire              idle_w     = (state_q == ST_IDLE);
    wire              pop_w      = rd_i && hit(addr_i, ADDR_RXDATA) && avail_w;

    // Eight-bit characters arrive in the top bits of the shifter
    wire [CHAR_W-1:0] char_w   = nine_w ? shift_q : {1'b0, shift_q[CHAR_W-1:1]};
    wire              ones_w   = (^char_w) ^ par_q;
    wire              parity_error_flag_w   = par_en_w && ((par_mode_w == PAR_ODD) ? !ones_w : ones_w);
    wire              framing_error_flag_w   = !rx_sync_q;
    // Plain data characters are dropped while hunting for an address
    wire              skip_w   = nine_w && address_detect_enable_q && !char_w[CHAR_W-1];
    // No capture while overrun stands; software must clear it first
    wire              accept_w = done_w && !skip_w && !overrun_q;
    wire              push_w   = accept_w && !full_w;
    wire              ovr_set_w = accept_w && full_w;
    // Only a 1 to 0 change flushes; writing a one is ignored
    wire              flush_w  = wr_stat_w && !wdata_i[BIT_OVR] && overrun_q
                                 && !ovr_set_w;

    ////////////////////////////////////////////////////////////////////////////
    // Receive state machine

    always_comb begin
        state_d = state_q;
        cnt_d   = tick_w ? 16'h0000 : cnt_q - 16'h0001;
        bit_d   = bit_q;
        shift_d = shift_q;
        par_d   = par_q;
        case (state_q)
            ST_IDLE: begin
                cnt_d = cnt_q;
                if (!rx_sync_q) begin
                    state_d = ST_START;
                    cnt_d   = baud_q >> 1;
                end
            end
            ST_START: begin
                if (tick_w) begin
                    cnt_d   = baud_q;
                    bit_d   = '0;
                    state_d = rx_sync_q ? ST_IDLE : ST_DATA;
                end
            end
            ST_DATA: begin
                if (tick_w) begin
                    cnt_d   = baud_q;
                    shift_d = {rx_sync_q, shift_q[CHAR_W-1:1]};
                    bit_d   = bit_q + 4'h1;
                    if (bit_q == last_w) begin
                        state_d = par_en_w ? ST_PARITY : ST_STOP;
                    end
                end
            end
            ST_PARITY: begin
                if (tick_w) begin
                    cnt_d   = baud_q;
                    par_d   = rx_sync_q;
                    state_d = ST_STOP;
                end
            end
            ST_STOP: begin
                if (tick_w) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (flush_w) begin
            state_d = ST_IDLE;
            shift_d = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Queue control

    assign entry_w    = '{parity_error_flag: parity_error_flag_w, framing_error_flag: framing_error_flag_w, data: char_w};
    assign count_d    = flush_w ? '0 : count_q + CNT_W'(push_w) - CNT_W'(pop_w);
    assign wptr_d     = flush_w ? '0 : wptr_q + PTR_W'(push_w);
    assign rptr_d     = flush_w ? '0 : rptr_q + PTR_W'(pop_w);

    ursts_fifo_mem u_mem (
        .mclk_i  (mclk_i),
        .ce_i    (ce_i),
        .we_i    (push_w),
        .waddr_i (wptr_q),
        .wdata_i (entry_w),
        .raddr_i (rptr_d),
        .rdata_o (head_w)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register read side

    always_comb begin
        status_w            = '0;
        status_w[BIT_ADDRESS_DETECT_ENABLE] = address_detect_enable_q;
        status_w[BIT_IDLE]  = idle_w;
        status_w[BIT_PARITY_ERROR_FLAG]  = avail_w && head_w.parity_error_flag;
        status_w[BIT_FRAMING_ERROR_FLAG]  = avail_w && head_w.framing_error_flag;
        status_w[BIT_OVR]   = overrun_q;
        status_w[BIT_AVAIL] = avail_w;
    end

    assign rd_mux_w =
        hit(addr_i, ADDR_STATUS)   ? status_w :
        hit(addr_i, ADDR_MODE)     ? DATA_W'(mode_q) :
        hit(addr_i, ADDR_BAUD)     ? baud_q :
        hit(addr_i, ADDR_RXDATA)   ? (avail_w ? DATA_W'(head_w.data) : '0) :
        hit(addr_i, ADDR_INT_STAT) ? DATA_W'(int_stat_q) :
        hit(addr_i, ADDR_INT_MASK) ? DATA_W'(int_mask_q) : '0;

    // New events win over a write-one clear in the same cycle
    assign int_ev_w[INT_RX]  = push_w;
    assign int_ev_w[INT_OVR] = ovr_set_w;
    assign int_ev_w[INT_ERR] = push_w && (parity_error_flag_w || framing_error_flag_w);
    assign int_stat_d = int_ev_w | (int_stat_q & ~(wr_ist_w ? wdata_i[INT_W-1:0] : '0));

    ////////////////////////////////////////////////////////////////////////////
    // Flip-flops

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            state_q   <= ST_IDLE;
            cnt_q     <= '0;
            bit_q     <= '0;
            shift_q   <= '0;
            par_q     <= 1'b0;
        end else if (ce_i) begin
            rx_meta_q <= rx_i;
            rx_sync_q <= rx_meta_q;
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            bit_q     <= bit_d;
            shift_q   <= shift_d;
            par_q     <= par_d;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            overrun_q <= 1'b0;
            count_q   <= '0;
            wptr_q    <= '0;
            rptr_q    <= '0;
        end else if (ce_i) begin
            overrun_q <= ovr_set_w || (overrun_q && !flush_w);
            count_q   <= count_d;
            wptr_q    <= wptr_d;
            rptr_q    <= rptr_d;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            address_detect_enable_q    <= 1'b0;
            mode_q     <= '0;
            baud_q     <= BAUD_RESET;
            int_stat_q <= '0;
            int_mask_q <= '0;
            rdata_o    <= '0;
            irq_o      <= 1'b0;
        end else if (ce_i) begin
            if (wr_stat_w) address_detect_enable_q <= wdata_i[BIT_ADDRESS_DETECT_ENABLE];
            if (wr_mode_w) mode_q <= wdata_i[MODE_W-1:0];
            if (wr_baud_w) baud_q <= wdata_i;
            if (wr_imask_w) int_mask_q <= wdata_i[INT_W-1:0];
            int_stat_q <= int_stat_d;
            rdata_o    <= rd_i ? rd_mux_w : '0;
            irq_o      <= |(int_stat_q & int_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_addr_skip: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && done_w && nine_w && address_detect_enable_q && !char_w[CHAR_W-1] && !flush_w)
        |=> (count_q == $past(count_q) - CNT_W'($past(pop_w))))
        else $error("data character stored during address hunt");

    a_idle_read: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && rd_i && hit(addr_i, ADDR_STATUS))
        |=> (rdata_o[BIT_IDLE] == $past(state_q == ST_IDLE)))
        else $error("idle flag disagrees with receiver state");

    a_parity_error_flag_head: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && push_w && (count_q == '0))
        |=> (head_w.parity_error_flag == $past(parity_error_flag_w)))
        else $error("parity flag not carried to head entry");

    a_framing_error_flag_head: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && push_w && (count_q == '0))
        |=> (head_w.framing_error_flag == $past(framing_error_flag_w)))
        else $error("framing flag not carried to head entry");

    a_ovr_no_set: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && !overrun_q && !ovr_set_w && wr_stat_w && wdata_i[BIT_OVR])
        |=> !overrun_q)
        else $error("software set the overrun flag");

    a_ovr_flush: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && overrun_q && wr_stat_w && !wdata_i[BIT_OVR])
        |=> (count_q == '0) && (state_q == ST_IDLE) && !overrun_q)
        else $error("overrun clear did not flush receiver");

    a_avail_read: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && rd_i && hit(addr_i, ADDR_STATUS))
        |=> (rdata_o[BIT_AVAIL] == ($past(count_q) != '0)))
        else $error("data available flag wrong");

    a_head_step: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && pop_w && !push_w && !flush_w)
        |=> (rptr_q == $past(rptr_q) + PTR_W'(1)) && (count_q == $past(count_q) - CNT_W'(1)))
        else $error("head did not advance on read");

    a_irq_level: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ce_i |=> (irq_o == $past(|(int_stat_q & int_mask_q))))
        else $error("interrupt output wrong");

endmodule : ursts_core

/* pkg/ursts_pkg.sv */
// Constants, types and register map of the receive status block
package ursts_pkg;

    // Register bus geometry
    localparam int unsigned ADDR_W    = 4;
    localparam int unsigned DATA_W    = 16;

    // Register offsets
    localparam logic [3:0]  ADDR_STATUS   = 4'h0;
    localparam logic [3:0]  ADDR_MODE     = 4'h1;
    localparam logic [3:0]  ADDR_BAUD     = 4'h2;
    localparam logic [3:0]  ADDR_RXDATA   = 4'h3;
    localparam logic [3:0]  ADDR_INT_STAT = 4'h4;
    localparam logic [3:0]  ADDR_INT_MASK = 4'h5;

    // Status and control field positions
    localparam int unsigned BIT_ADDRESS_DETECT_ENABLE = 5;
    localparam int unsigned BIT_IDLE  = 4;
    localparam int unsigned BIT_PARITY_ERROR_FLAG  = 3;
    localparam int unsigned BIT_FRAMING_ERROR_FLAG  = 2;
    localparam int unsigned BIT_OVR   = 1;
    localparam int unsigned BIT_AVAIL = 0;

    // Mode register fields
    localparam int unsigned MODE_W     = 3;
    localparam int unsigned MODE_NINE  = 0;
    localparam int unsigned MODE_PAR   = 1;
    localparam int unsigned PAR_W      = 2;
    localparam logic [1:0]  PAR_NONE   = 2'h0;
    localparam logic [1:0]  PAR_EVEN   = 2'h1;
    localparam logic [1:0]  PAR_ODD    = 2'h2;

    // Interrupt sources
    localparam int unsigned INT_W   = 3;
    localparam int unsigned INT_RX  = 0;
    localparam int unsigned INT_OVR = 1;
    localparam int unsigned INT_ERR = 2;

    // Receive queue
    localparam int unsigned FIFO_DEPTH = 4;
    localparam int unsigned PTR_W      = 2;
    localparam int unsigned CNT_W      = 3;
    localparam logic [2:0]  CNT_FULL   = 3'h4;

    // Character framing
    localparam int unsigned CHAR_W   = 9;
    localparam logic [3:0]  LAST_8   = 4'h7;
    localparam logic [3:0]  LAST_9   = 4'h8;

    // Cycles per bit minus one; default near 115200 baud at 50 MHz
    localparam logic [15:0] BAUD_RESET = 16'h01b1;

    typedef struct packed {
        logic              parity_error_flag;
        logic              framing_error_flag;
        logic [CHAR_W-1:0] data;
    } ursts_entry_s;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_START  = 5'h02,
        ST_DATA   = 5'h04,
        ST_PARITY = 5'h08,
        ST_STOP   = 5'h10
    } ursts_rx_state_e;

endpackage : ursts_pkg

/* hw/ursts_fifo_mem.sv */
// Receive queue storage with registered, write-through read port
`timescale 1ns/1ps
module ursts_fifo_mem
    import ursts_pkg::*;
(
    input  wire logic             mclk_i,
    input  wire logic             ce_i,
    input  wire logic             we_i,
    input  wire logic [PTR_W-1:0] waddr_i,
    input  wire ursts_entry_s     wdata_i,
    input  wire logic [PTR_W-1:0] raddr_i,
    output ursts_entry_s          rdata_o
);

    ursts_entry_s mem_q [FIFO_DEPTH];
    ursts_entry_s rdata_q;
    wire          bypass_w = we_i && (waddr_i == raddr_i);

    // Bypass keeps the head entry valid in the same cycle as the count
    always_ff @(posedge mclk_i) begin
        if (ce_i) begin
            if (we_i) begin
                mem_q[waddr_i] <= wdata_i;
            end
            rdata_q <= bypass_w ? wdata_i : mem_q[raddr_i];
        end
    end

    assign rdata_o = rdata_q;

endmodule : ursts_fifo_mem

/* sim/ursts_tx_model.sv */
// Behavioural far-end serial transmitter that drives the receive line
`timescale 1ns/1ps
module ursts_tx_model (
    input  wire logic mclk_i,
    output logic      tx_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // Line idles high, so no settling guess is needed between frames
    initial tx_o = 1'b1;

    // Start, data LSB first, optional parity, one stop, then one idle bit time
    // so that the receiver's mid-stop sample is done before the task returns
    task automatic send(input logic [8:0] d, input logic nine, input logic [1:0] par,
                        input logic bad_par, input logic bad_stop, input int unsigned bclk);
        logic q[$];
        logic p;
        q.push_back(1'b0);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            q.push_back(d[i]);
        end
        // Even parity unless odd is chosen; corrupted only when a test asks
        p = (^d[7:0]) ^ (par == 2'h2) ^ bad_par;
        if (!nine && par != 2'h0) begin
            q.push_back(p);
        end
        q.push_back(~bad_stop);
        q.push_back(1'b1);
        foreach (q[i]) begin
            tx_o <= q[i];
            repeat (bclk) @(posedge mclk_i);
        end
    endtask : send
endmodule : ursts_tx_model

/* sim/tb.sv */
// Self-checking bench for the receive status block
`timescale 1ns/1ps
module tb;
    import ursts_pkg::*;
    localparam int unsigned BCLK  = 8;
    localparam int unsigned LIMIT = 20000;

    logic              mclk_i   = 1'b0;
    logic              resetn_i = 1'b0;
    logic              ce_i     = 1'b1;
    logic              wr_i     = 1'b0;
    logic              rd_i     = 1'b0;
    logic [ADDR_W-1:0] addr_i   = '0;
    logic [DATA_W-1:0] wdata_i  = '0;
    logic              rx_i;
    logic [DATA_W-1:0] rdata_o;
    logic              irq_o;
    logic [DATA_W-1:0] v;
    int                n_fail      = 0;
    int                comparisons = 0;
    int                cycles      = 0;

    ////////////////////////////////////////////////////////////////////////////////
    always #10 mclk_i = ~mclk_i;

    ursts_core u_dut (
        .mclk_i  (mclk_i),
        .resetn_i(resetn_i),
        .ce_i    (ce_i),
        .rx_i    (rx_i),
        .addr_i  (addr_i),
        .wdata_i (wdata_i),
        .wr_i    (wr_i),
        .rd_i    (rd_i),
        .rdata_o (rdata_o),
        .irq_o   (irq_o)
    );

    ursts_tx_model u_tx (
        .mclk_i(mclk_i),
        .tx_o  (rx_i)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // A hung receiver would otherwise stall the run forever
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_fail++;
            conclude();
        end
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the strobe; sampled mid-cycle
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        d = rdata_o;
    endtask : rd

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_rd(input string what, input logic [3:0] a, input logic [15:0] exp);
        rd(a, v);
        chk(what, exp, v);
    endtask : chk_rd

    task automatic tx(input logic [8:0] d, input logic nine, input logic [1:0] par,
                      input logic bp, input logic bs);
        @(posedge mclk_i);
        u_tx.send(d, nine, par, bp, bs, BCLK);
    endtask : tx

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge mclk_i);
        resetn_i <= 1'b1;
        chk_rd("status reset", ADDR_STATUS, 16'h0010);
        chk_rd("baud reset", ADDR_BAUD, BAUD_RESET);
        chk_rd("mask reset", ADDR_INT_MASK, 16'h0000);
        chk_rd("unmapped", 4'hf, 16'h0000);
        wr(ADDR_BAUD, 16'(BCLK - 1));
        wr(ADDR_INT_MASK, 16'h0007);
        $display("test reset done");

        fork
            tx(9'h05a, 1'b0, PAR_NONE, 1'b0, 1'b0);
            begin
                repeat (30) @(posedge mclk_i);
                chk_rd("status busy", ADDR_STATUS, 16'h0000);
            end
        join
        chk_rd("status avail", ADDR_STATUS, 16'h0011);
        chk("irq rx", 16'h0001, {15'h0, irq_o});
        chk_rd("int stat rx", ADDR_INT_STAT, 16'h0001);
        chk_rd("rx data", ADDR_RXDATA, 16'h005a);
        chk_rd("status empty", ADDR_STATUS, 16'h0010);
        wr(ADDR_INT_STAT, 16'h0007);
        repeat (2) @(negedge mclk_i);
        chk("irq cleared", 16'h0000, {15'h0, irq_o});
        $display("test single char done");

        wr(ADDR_MODE, {13'h0, PAR_EVEN, 1'b0});
        tx(9'h0c3, 1'b0, PAR_EVEN, 1'b1, 1'b0);
        tx(9'h011, 1'b0, PAR_EVEN, 1'b0, 1'b0);
        tx(9'h07e, 1'b0, PAR_EVEN, 1'b0, 1'b1);
        chk_rd("status parity_error_flag", ADDR_STATUS, 16'h0019);
        chk_rd("int stat err", ADDR_INT_STAT, 16'h0005);
        chk_rd("data parity_error_flag", ADDR_RXDATA, 16'h00c3);
        chk_rd("status next", ADDR_STATUS, 16'h0011);
        chk_rd("data good", ADDR_RXDATA, 16'h0011);
        chk_rd("status framing_error_flag", ADDR_STATUS, 16'h0015);
        chk_rd("data framing_error_flag", ADDR_RXDATA, 16'h007e);
        chk_rd("status drained", ADDR_STATUS, 16'h0010);
        wr(ADDR_MODE, {13'h0, PAR_ODD, 1'b0});
        chk_rd("mode odd", ADDR_MODE, 16'h0004);
        tx(9'h0f0, 1'b0, PAR_ODD, 1'b0, 1'b0);
        tx(9'h0f1, 1'b0, PAR_ODD, 1'b1, 1'b0);
        chk_rd("status odd ok", ADDR_STATUS, 16'h0011);
        chk_rd("data odd ok", ADDR_RXDATA, 16'h00f0);
        chk_rd("status odd bad", ADDR_STATUS, 16'h0019);
        chk_rd("data odd bad", ADDR_RXDATA, 16'h00f1);
        // Parity code 11 behaves as even
        wr(ADDR_MODE, 16'h0006);
        tx(9'h0c3, 1'b0, PAR_EVEN, 1'b1, 1'b0);
        chk_rd("status par 11", ADDR_STATUS, 16'h0019);
        chk_rd("data par 11", ADDR_RXDATA, 16'h00c3);
        $display("test errors done");

        wr(ADDR_MODE, 16'h0000);
        wr(ADDR_INT_STAT, 16'h0007);
        for (int i = 0; i < 5; i++) begin
            tx(9'(8'h10 + i), 1'b0, PAR_NONE, 1'b0, 1'b0);
        end
        chk_rd("status overrun", ADDR_STATUS, 16'h0013);
        chk_rd("int stat ovr", ADDR_INT_STAT, 16'h0003);
        wr(ADDR_INT_MASK, 16'h0001);
        wr(ADDR_INT_STAT, 16'h0001);
        repeat (2) @(negedge mclk_i);
        chk("irq masked", 16'h0000, {15'h0, irq_o});
        wr(ADDR_INT_MASK, 16'h0002);
        repeat (2) @(negedge mclk_i);
        chk("irq ovr", 16'h0001, {15'h0, irq_o});
        wr(ADDR_STATUS, 16'h0002);
        chk_rd("ovr write one", ADDR_STATUS, 16'h0013);
        wr(ADDR_STATUS, 16'h0000);
        chk_rd("status flushed", ADDR_STATUS, 16'h0010);
        chk_rd("data flushed", ADDR_RXDATA, 16'h0000);
        wr(ADDR_STATUS, 16'h0002);
        chk_rd("ovr not set", ADDR_STATUS, 16'h0010);
        tx(9'h077, 1'b0, PAR_NONE, 1'b0, 1'b0);
        chk_rd("data after flush", ADDR_RXDATA, 16'h0077);
        $display("test overrun done");

        wr(ADDR_MODE, 16'h0001);
        wr(ADDR_STATUS, 16'h0020);
        tx(9'h0a5, 1'b1, PAR_NONE, 1'b0, 1'b0);
        tx(9'h1a5, 1'b1, PAR_NONE, 1'b0, 1'b0);
        chk_rd("status addr", ADDR_STATUS, 16'h0031);
        chk_rd("data addr", ADDR_RXDATA, 16'h01a5);
        chk_rd("status addr empty", ADDR_STATUS, 16'h0030);
        wr(ADDR_MODE, 16'h0000);
        tx(9'h033, 1'b0, PAR_NONE, 1'b0, 1'b0);
        chk_rd("data eight bit", ADDR_RXDATA, 16'h0033);
        $display("test address detect done");

        // A write while the enable is low must leave no trace
        @(posedge mclk_i);
        ce_i <= 1'b0;
        wr(ADDR_INT_MASK, 16'h0005);
        ce_i <= 1'b1;
        chk_rd("mask frozen", ADDR_INT_MASK, 16'h0002);
        $display("test clock enable done");
        conclude();
    end
endmodule : tb
